// ---- compare_regs_pkg.sv ----
// Shared constants, encodings and helpers for the compare control block
package compare_regs_pkg;

  // Data-memory addresses of the registers
  localparam logic [15:0] ADDR_COMPARE_CONTROL = 16'h7411;
  localparam logic [15:0] ADDR_FULL_ACTION = 16'h7413;
  localparam logic [15:0] ADDR_SIMPLE_ACTION = 16'h7414;
  localparam logic [15:0] ADDR_FULL_CMP1 = 16'h7417;
  localparam logic [15:0] ADDR_SIMPLE_CMP1 = 16'h741A;

  // Widths and counts
  localparam int DATA_W = 16;
  localparam int NUM_UNITS = 3;
  localparam int NUM_FULL_PINS = 6;
  localparam int ACT_W = 2;
  localparam int SIMPLE_ACT_W = 6;

  // Compare control field positions
  localparam int FULL_CMP_ON_BIT = 15;
  localparam int CMP_RELOAD_LSB = 13;
  localparam int SPACE_VECTOR_ON_BIT = 12;
  localparam int ACTION_RELOAD_LSB = 10;
  localparam int FULL_OUT_DRIVE_BIT = 9;
  localparam int SIMPLE_OUT_DRIVE_BIT = 8;
  localparam int SIMPLE_TIMEBASE_BIT = 7;
  localparam int SIMPLE_CMP_RELOAD_LSB = 5;
  localparam int SIMPLE_ACTION_RELOAD_LSB = 3;
  localparam int UNIT1_PWM_BIT = 0;

  // Full action register field positions
  localparam int VECTOR_DIR_BIT = 15;
  localparam int BASIC_VECTOR_LSB = 12;
  localparam int BASIC_VECTOR_W = 3;

  // Reset values
  localparam logic [15:0] COMPARE_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] FULL_ACTION_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_ZERO = 16'h0000;

  // Shadow reload selections
  typedef enum logic [1:0] {
    RELOAD_ON_ZERO = 2'h0,
    RELOAD_ON_ZERO_PERIOD = 2'h1,
    RELOAD_NOW = 2'h2,
    RELOAD_RESERVED = 2'h3
  } reload_sel_type;

  // Pin action codes, compare mode meaning and PWM mode meaning
  typedef enum logic [1:0] {
    ACT_HOLD = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } pin_action_type;

  localparam logic [1:0] PWM_FORCED_LOW = 2'h0;
  localparam logic [1:0] PWM_ACTIVE_LOW = 2'h1;
  localparam logic [1:0] PWM_ACTIVE_HIGH = 2'h2;
  localparam logic [1:0] PWM_FORCED_HIGH = 2'h3;

  // Whether a shadow reload happens this cycle
  function automatic logic reload_now(input logic [1:0] sel,
                                      input logic [15:0] cnt,
                                      input logic [15:0] per);
    logic hit;
    hit = 1'b0;
    case (sel)
      RELOAD_ON_ZERO: hit = (cnt == COUNTER_ZERO);
      RELOAD_ON_ZERO_PERIOD: hit = (cnt == COUNTER_ZERO) || (cnt == per);
      RELOAD_NOW: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// ---- pin_action_stage.sv ----
// One compare/PWM output pin: action decode and registered pin level
`timescale 1ns/1ps
module pin_action_stage (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic pwm_mode_in,
  input wire logic [compare_regs_pkg::ACT_W-1:0] action_in,
  input wire logic match_in,
  input wire logic cycle_start_in,
  output logic level_out
);
  import compare_regs_pkg::*;

  typedef struct packed {
    logic level;
    logic wave;
  } pin_state_type;

  pin_state_type s_q;
  pin_state_type s_d;

  // Compare mode: new level from action and present level
  function automatic logic cmp_level(input logic [1:0] act,
                                     input logic cur);
    logic v;
    v = cur;
    case (act)
      ACT_HOLD: v = cur;
      ACT_LOW: v = 1'b0;
      ACT_HIGH: v = 1'b1;
      ACT_TOGGLE: v = ~cur;
      default: v = cur;
    endcase
    return v;
  endfunction

  // PWM mode: pin level from action and raw waveform
  function automatic logic pwm_level(input logic [1:0] act,
                                     input logic wave);
    logic v;
    v = 1'b0;
    case (act)
      PWM_FORCED_LOW: v = 1'b0;
      PWM_ACTIVE_LOW: v = ~wave;
      PWM_ACTIVE_HIGH: v = wave;
      PWM_FORCED_HIGH: v = 1'b1;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // Next state; nothing moves while the pin is not running
  always_comb begin
    s_d = s_q;
    if (run_in) begin
      if (pwm_mode_in) begin
        if (match_in) begin
          s_d.wave = 1'b1;
        end else if (cycle_start_in) begin
          s_d.wave = 1'b0;
        end
        s_d.level = pwm_level(action_in, s_d.wave);
      end else if (match_in) begin
        s_d.level = cmp_level(action_in, s_q.level);
      end
    end
  end

  // State register, frozen by the clock enable
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

  a_toggle_on_match: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && run_in && !pwm_mode_in && match_in && action_in == ACT_TOGGLE
    |=> level_out != $past(level_out))
    else $error("compare toggle did not invert pin");

  a_pwm_forced_levels: assert property (
    @(posedge ref_clk_in) disable iff (reset_in)
    ce_in && run_in && pwm_mode_in &&
    (action_in == PWM_FORCED_HIGH || action_in == PWM_FORCED_LOW)
    |=> level_out == $past(action_in[1]))
    else $error("forced pwm level wrong");

endmodule

// ---- compare_control_action_regs.sv ----
// Compare control, action and compare registers with pin output logic
// Operation
// - Compare enable low stops full compare; all shadows pass writes through.
// - Full compare reload: 00 zero, 01 zero or period, 10 now.
// - Space-vector enable forces all six full outputs to PWM mode.
// - Full action reload: 00 zero, 01 zero or period, 10 now.
// - Bit 9 drives full pins; protection input clears it.
// - Bit 8 drives simple pins; protection input clears it.
// - Bit 7 picks timer 1 or timer 2 for simple units.
// - Simple compare reload per field, on the selected timer.
// - Simple action reload per field, on the selected timer.
// - Bits 2..0 choose compare or PWM mode for units 3..1.
// - Full actions reach pins on match only while compare enabled.
// - Full action shadow moves to active only at its reload point while compare is enabled; every cycle while compare is disabled.
// - Action bit 15 is rotation direction, used only in space-vector.
// - Action bits 14..12 are basic vector bits, space-vector only.
// - Action codes: hold/low/high/toggle or forced/active low/high/forced.
// - Pin 6 at 11..10, pin 5 9..8, down to pin 1.
// - Control and full action bits are read/write, zero after reset.
// - No full output transition during timer 1 directional up/down.
// - Reset clears compare registers and floats all compare pins.
`timescale 1ns/1ps
module compare_control_action_regs (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [compare_regs_pkg::DATA_W-1:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [compare_regs_pkg::DATA_W-1:0] wdata_in,
  output logic [compare_regs_pkg::DATA_W-1:0] rdata_out,
  input wire logic [compare_regs_pkg::DATA_W-1:0] timer1_counter_in,
  input wire logic [compare_regs_pkg::DATA_W-1:0] timer1_period_in,
  input wire logic [compare_regs_pkg::DATA_W-1:0] timer2_counter_in,
  input wire logic [compare_regs_pkg::DATA_W-1:0] timer2_period_in,
  input wire logic timer1_updown_dir_mode_in,
  input wire logic power_drive_protect_in,
  output logic [compare_regs_pkg::NUM_FULL_PINS-1:0] full_pin_out,
  output logic [compare_regs_pkg::NUM_FULL_PINS-1:0] full_pin_oe_out,
  output logic [compare_regs_pkg::NUM_UNITS-1:0] simple_pin_out,
  output logic [compare_regs_pkg::NUM_UNITS-1:0] simple_pin_oe_out,
  output logic vector_rotation_dir_out,
  output logic [compare_regs_pkg::BASIC_VECTOR_W-1:0] basic_vector_out
);
  import compare_regs_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] compare_control;
    logic [DATA_W-1:0] action_shadow;
    logic [DATA_W-1:0] action_active;
    logic [SIMPLE_ACT_W-1:0] simple_action_shadow;
    logic [SIMPLE_ACT_W-1:0] simple_action_active;
    logic [NUM_UNITS-1:0][DATA_W-1:0] full_shadow;
    logic [NUM_UNITS-1:0][DATA_W-1:0] full_active;
    logic [NUM_UNITS-1:0][DATA_W-1:0] simple_shadow;
    logic [NUM_UNITS-1:0][DATA_W-1:0] simple_active;
    logic [DATA_W-1:0] rd_data;
  } regs_type;

  regs_type r_q;
  regs_type r_d;

  // Decoded control fields
  logic full_cmp_on;
  logic space_vector_on;
  logic full_out_drive;
  logic simple_out_drive;
  logic simple_timebase_sel;
  logic [1:0] cmp_reload_sel;
  logic [1:0] action_reload_sel;
  logic [1:0] simple_cmp_reload_sel;
  logic [1:0] simple_action_reload_sel;
  logic [NUM_UNITS-1:0] unit_pwm_sel;
  logic [NUM_UNITS-1:0] unit_pwm_mode;
  logic [DATA_W-1:0] simple_counter;
  logic [DATA_W-1:0] simple_period;
  logic full_run;
  logic transparent;
  logic load_full;
  logic load_action;
  logic load_simple;
  logic load_simple_action;

  assign full_cmp_on = r_q.compare_control[FULL_CMP_ON_BIT];
  assign space_vector_on = r_q.compare_control[SPACE_VECTOR_ON_BIT];
  assign full_out_drive = r_q.compare_control[FULL_OUT_DRIVE_BIT];
  assign simple_out_drive = r_q.compare_control[SIMPLE_OUT_DRIVE_BIT];
  assign simple_timebase_sel = r_q.compare_control[SIMPLE_TIMEBASE_BIT];
  assign cmp_reload_sel = r_q.compare_control[CMP_RELOAD_LSB +: 2];
  assign action_reload_sel = r_q.compare_control[ACTION_RELOAD_LSB +: 2];
  assign simple_cmp_reload_sel =
    r_q.compare_control[SIMPLE_CMP_RELOAD_LSB +: 2];
  assign simple_action_reload_sel =
    r_q.compare_control[SIMPLE_ACTION_RELOAD_LSB +: 2];
  assign unit_pwm_sel = r_q.compare_control[UNIT1_PWM_BIT +: NUM_UNITS];

  // Space-vector mode overrides the per-unit mode bits
  assign unit_pwm_mode = space_vector_on ? {NUM_UNITS{1'b1}}
                                         : unit_pwm_sel;

  // Simple units time base
  assign simple_counter = simple_timebase_sel ? timer2_counter_in
                                              : timer1_counter_in;
  assign simple_period = simple_timebase_sel ? timer2_period_in
                                             : timer1_period_in;

  // Shadow to active transfer conditions
  assign transparent = !full_cmp_on;
  assign load_full = transparent ||
    reload_now(cmp_reload_sel, timer1_counter_in,
               timer1_period_in);
  assign load_action = transparent ||
    reload_now(action_reload_sel, timer1_counter_in,
               timer1_period_in);
  assign load_simple = transparent ||
    reload_now(simple_cmp_reload_sel, simple_counter,
               simple_period);
  assign load_simple_action = transparent ||
    reload_now(simple_action_reload_sel, simple_counter,
               simple_period);

  // Register writes, protection clears, reloads and read data
  always_comb begin
    r_d = r_q;
    if (wr_en_in) begin
      if (addr_in == ADDR_COMPARE_CONTROL) begin
        r_d.compare_control = wdata_in;
      end
      if (addr_in == ADDR_FULL_ACTION) begin
        r_d.action_shadow = wdata_in;
      end
      if (addr_in == ADDR_SIMPLE_ACTION) begin
        r_d.simple_action_shadow = wdata_in[SIMPLE_ACT_W-1:0];
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (addr_in == ADDR_FULL_CMP1 + 16'(u)) begin
          r_d.full_shadow[u] = wdata_in;
        end
        if (addr_in == ADDR_SIMPLE_CMP1 + 16'(u)) begin
          r_d.simple_shadow[u] = wdata_in;
        end
      end
    end
    if (power_drive_protect_in) begin
      r_d.compare_control[FULL_OUT_DRIVE_BIT] = 1'b0;
      r_d.compare_control[SIMPLE_OUT_DRIVE_BIT] = 1'b0;
    end
    // Immediate and transparent loads pass the just-written value
    if (load_full) begin
      r_d.full_active = r_d.full_shadow;
    end
    if (load_action) begin
      r_d.action_active = r_d.action_shadow;
    end
    if (load_simple) begin
      r_d.simple_active = r_d.simple_shadow;
    end
    if (load_simple_action) begin
      r_d.simple_action_active = r_d.simple_action_shadow;
    end
    if (rd_en_in) begin
      r_d.rd_data = '0;
      if (addr_in == ADDR_COMPARE_CONTROL) begin
        r_d.rd_data = r_q.compare_control;
      end
      if (addr_in == ADDR_FULL_ACTION) begin
        r_d.rd_data = r_q.action_shadow;
      end
      if (addr_in == ADDR_SIMPLE_ACTION) begin
        r_d.rd_data = {{(DATA_W-SIMPLE_ACT_W){1'b0}},
                       r_q.simple_action_shadow};
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (addr_in == ADDR_FULL_CMP1 + 16'(u)) begin
          r_d.rd_data = r_q.full_shadow[u];
        end
        if (addr_in == ADDR_SIMPLE_CMP1 + 16'(u)) begin
          r_d.rd_data = r_q.simple_shadow[u];
        end
      end
    end
  end

  // State register; reset wins over the clock enable
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      r_q <= '0;
    end else if (ce_in) begin
      r_q <= r_d;
    end
  end

  assign rdata_out = r_q.rd_data;

  // Full pins run only when enabled and not in directional up/down
  assign full_run = full_cmp_on && !timer1_updown_dir_mode_in;

  // Full compare pins, two per unit, actions from the active copy
  genvar k;
  generate
    for (k = 0; k < NUM_FULL_PINS; k++) begin : g_full_pin
      pin_action_stage u_pin (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .run_in(full_run),
        .pwm_mode_in(unit_pwm_mode[k/2]),
        .action_in(r_q.action_active[ACT_W*k +: ACT_W]),
        .match_in(timer1_counter_in == r_q.full_active[k/2]),
        .cycle_start_in(timer1_counter_in == COUNTER_ZERO),
        .level_out(full_pin_out[k])
      );
    end
  endgenerate

  // Simple compare pins on the selected time base, always PWM coded
  genvar j;
  generate
    for (j = 0; j < NUM_UNITS; j++) begin : g_simple_pin
      pin_action_stage u_pin (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .run_in(1'b1),
        .pwm_mode_in(1'b1),
        .action_in(r_q.simple_action_active[ACT_W*j +: ACT_W]),
        .match_in(simple_counter == r_q.simple_active[j]),
        .cycle_start_in(simple_counter == COUNTER_ZERO),
        .level_out(simple_pin_out[j])
      );
    end
  endgenerate

  // Pin drivers; disabled compare floats the full pins
  assign full_pin_oe_out = {NUM_FULL_PINS{full_out_drive && full_cmp_on}};
  assign simple_pin_oe_out = {NUM_UNITS{simple_out_drive}};

  // Space-vector fields leave the block only in space-vector mode
  assign vector_rotation_dir_out =
    space_vector_on && r_q.action_active[VECTOR_DIR_BIT];
  assign basic_vector_out = space_vector_on ?
    r_q.action_active[BASIC_VECTOR_LSB +: BASIC_VECTOR_W]
    : '0;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_protect;
    ce_in && power_drive_protect_in;
  endsequence

  sequence s_drive_off;
    !full_out_drive && !simple_out_drive && full_pin_oe_out == '0 &&
    simple_pin_oe_out == '0;
  endsequence

  sequence s_transparent_write;
    ce_in && transparent && wr_en_in && addr_in == ADDR_FULL_CMP1;
  endsequence

  a_protect_clears_drive: assert property (
    s_protect |=> s_drive_off)
    else $error("protection did not clear output drive bits");

  a_transparent_cmp: assert property (
    s_transparent_write |=> r_q.full_active[0] == $past(wdata_in))
    else $error("transparent write did not reach active compare");

  a_reload_hold_zero: assert property (
    ce_in && full_cmp_on && cmp_reload_sel == RELOAD_ON_ZERO &&
    timer1_counter_in != COUNTER_ZERO |=> $stable(r_q.full_active))
    else $error("full compare reloaded off its zero point");

  a_action_reload_now: assert property (
    ce_in && action_reload_sel == RELOAD_NOW && !wr_en_in
    |=> r_q.action_active == r_q.action_shadow)
    else $error("immediate action reload missing");

  a_action_hold: assert property (
    ce_in && full_cmp_on && action_reload_sel == RELOAD_RESERVED
    |=> $stable(r_q.action_active))
    else $error("action active changed without reload");

  a_svm_all_pwm: assert property (
    space_vector_on |-> unit_pwm_mode == {NUM_UNITS{1'b1}})
    else $error("space vector mode not forcing pwm");

  a_updown_frozen: assert property (
    ce_in && timer1_updown_dir_mode_in |=> $stable(full_pin_out))
    else $error("full pin moved in directional up/down mode");

  a_disabled_float: assert property (
    !full_cmp_on |-> full_pin_oe_out == '0 && !full_run)
    else $error("full pins driven while compare disabled");

  a_reset_clears: assert property (
    $fell(reset_in) |-> r_q.compare_control == COMPARE_CONTROL_RESET &&
    r_q.action_shadow == FULL_ACTION_RESET && full_pin_oe_out == '0 &&
    simple_pin_oe_out == '0)
    else $error("registers or pins not cleared by reset");

  a_read_control: assert property (
    ce_in && rd_en_in && addr_in == ADDR_COMPARE_CONTROL
    |=> rdata_out == $past(r_q.compare_control))
    else $error("control register read back wrong");

  a_simple_timebase: assert property (
    simple_timebase_sel |-> simple_counter == timer2_counter_in)
    else $error("simple time base not timer 2");

endmodule

// ---- timer_partner.sv ----
// Timer model that feeds counter levels to the compare block
`timescale 1ns/1ps
module timer_partner (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] period1_in,
  input wire logic [15:0] period2_in,
  output logic [15:0] count1_out,
  output logic [15:0] count2_out
);
  // Continuous up counting, wrapping to zero after the period value
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count1_out <= 16'h0000;
      count2_out <= 16'h0000;
    end else begin
      count1_out <= (count1_out >= period1_in) ? 16'h0000 :
                    count1_out + 16'h0001;
      count2_out <= (count2_out >= period2_in) ? 16'h0000 :
                    count2_out + 16'h0001;
    end
  end
endmodule

// ---- compare_control_action_regs_test.sv ----
// Self-checking bench for the compare control and action registers
`timescale 1ns/1ps
module compare_control_action_regs_test;
  import compare_regs_pkg::*;
  logic clk, rst, wr, rd, updn, prot, vdir, pend, was, ce;
  logic [15:0] addr, wdata, rdata, cnt1, cnt2, v;
  logic [5:0] fpin, foe;
  logic [2:0] spin, soe, bvec;
  logic [15:0] exp_q[$];
  int fails, n_compared;

  timer_partner timer_partner_inst (.ref_clk_in(clk), .reset_in(rst),
    .period1_in(16'h0014), .period2_in(16'h000D),
    .count1_out(cnt1), .count2_out(cnt2));

  compare_control_action_regs compare_control_action_regs_inst (
    .ref_clk_in(clk), .reset_in(rst), .ce_in(ce), .addr_in(addr),
    .wr_en_in(wr), .rd_en_in(rd), .wdata_in(wdata), .rdata_out(rdata),
    .timer1_counter_in(cnt1), .timer1_period_in(16'h0014),
    .timer2_counter_in(cnt2), .timer2_period_in(16'h000D),
    .timer1_updown_dir_mode_in(updn), .power_drive_protect_in(prot),
    .full_pin_out(fpin), .full_pin_oe_out(foe), .simple_pin_out(spin),
    .simple_pin_oe_out(soe), .vector_rotation_dir_out(vdir),
    .basic_vector_out(bvec));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access, held for exactly one edge
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    #1 addr = a;
    wr = w;
    rd = ~w;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  // Bounded wait for a given timer 1 count
  task automatic wait_cnt(input logic [15:0] c);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (cnt1 !== c && n < 200);
    if (n >= 200) fails++;
  endtask

  // Load an action word, let one match at count 5 pass, check pins
  task automatic pin_step(input logic [15:0] act, input logic [5:0] e);
    wr_reg(ADDR_FULL_ACTION, act);
    wait_cnt(16'h0000);
    wait_cnt(16'h0007);
    check({10'h000, fpin}, {10'h000, e});
  endtask

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Read data watcher: oldest note against the answer one cycle later
  always @(posedge clk) begin
    was = pend;
    pend = rd && !rst;
    if (was) begin
      #1 check(rdata, exp_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    #500000 fails++;
    end_of_test;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, updn, prot} = 4'h0;
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    fails = 0;
    n_compared = 0;
    void'($urandom(60));
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check({4'h0, foe, fpin}, 16'h0000);
    check({10'h000, soe, spin}, 16'h0000);
    rd_reg(ADDR_COMPARE_CONTROL, 16'h0000);
    rd_reg(ADDR_FULL_ACTION, 16'h0000);
    rd_reg(16'h7412, 16'h0000);
    wr_reg(ADDR_COMPARE_CONTROL, 16'h4B50);
    wr_reg(ADDR_COMPARE_CONTROL, 16'hCB50);
    rd_reg(ADDR_COMPARE_CONTROL, 16'hCB50);
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_FULL_CMP1 + 16'(i), 16'h0005);
    end
    // Per-pin codes in compare mode: set, low, toggle, hold
    pin_step(16'h0666, 6'h15);
    pin_step(16'h0999, 6'h2A);
    pin_step(16'h0FFF, 6'h15);
    pin_step(16'h0000, 6'h15);
    check({10'h000, foe}, 16'h003F);
    updn = 1'b1;
    pin_step(16'h0AAA, 6'h15);
    updn = 1'b0;
    // Compare disabled: no pin action, shadows transparent
    wr_reg(ADDR_COMPARE_CONTROL, 16'h5B50);
    pin_step(16'h0555, 6'h15);
    check({10'h000, foe}, 16'h0000);
    wr_reg(ADDR_FULL_ACTION, 16'hD000);
    check({12'h000, vdir, bvec}, 16'h000D);
    // Action reload on zero, then on zero or period
    for (int s = 0; s < 2; s++) begin
      wr_reg(ADDR_COMPARE_CONTROL, 16'h5350 | 16'(s << 10));
      wr_reg(ADDR_COMPARE_CONTROL, 16'hD350 | 16'(s << 10));
      wait_cnt(16'h0003);
      wr_reg(ADDR_FULL_ACTION, (s == 1) ? 16'h8000 : 16'h0000);
      wait_cnt((s == 1) ? 16'h0014 : 16'h0000);
      check({15'h0000, vdir}, (s == 1) ? 16'h0000 : 16'h0001);
      wait_cnt((s == 1) ? 16'h0000 : 16'h0001);
      check({15'h0000, vdir}, (s == 1) ? 16'h0001 : 16'h0000);
    end
    // Space vector mode forces PWM decoding on all six pins
    wr_reg(ADDR_COMPARE_CONTROL, 16'h5B50);
    wr_reg(ADDR_COMPARE_CONTROL, 16'hDB50);
    pin_step(16'h0FFF, 6'h3F);
    pin_step(16'h0000, 6'h00);
    // Simple units on timer 2, forced high
    wr_reg(ADDR_COMPARE_CONTROL, 16'hDBD0);
    wr_reg(ADDR_SIMPLE_ACTION, 16'hFFFF);
    rd_reg(ADDR_SIMPLE_ACTION, 16'h003F);
    pin_step(16'h0000, 6'h00);
    check({10'h000, soe, spin}, 16'h003F);
    // Protection clears both output enables
    @(posedge clk);
    #1 prot = 1'b1;
    @(posedge clk);
    #1 prot = 1'b0;
    rd_reg(ADDR_COMPARE_CONTROL, 16'hD8D0);
    check({7'h00, foe, soe}, 16'h0000);
    // Clock enable low: a write is not taken
    ce = 1'b0;
    wr_reg(ADDR_COMPARE_CONTROL, 16'hFFFF);
    ce = 1'b1;
    rd_reg(ADDR_COMPARE_CONTROL, 16'hD8D0);
    // Random words read back from the written copy
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr_reg(ADDR_FULL_ACTION, v);
      rd_reg(ADDR_FULL_ACTION, v);
      wr_reg(ADDR_FULL_CMP1 + 16'(i % 3), ~v);
      rd_reg(ADDR_FULL_CMP1 + 16'(i % 3), ~v);
      wr_reg(ADDR_COMPARE_CONTROL, v ^ 16'h5A5A);
      rd_reg(ADDR_COMPARE_CONTROL, v ^ 16'h5A5A);
    end
    // Second reset in mid-run
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check({4'h0, foe, fpin}, 16'h0000);
    rd_reg(ADDR_COMPARE_CONTROL, 16'h0000);
    rd_reg(ADDR_FULL_ACTION, 16'h0000);
    repeat (3) @(posedge clk);
    end_of_test;
  end
endmodule
